/* bench/rx_client_sink.sv */
// client side model: logs delivered words and the end-of-frame flags.
// assumes the standard 256-bit client stream, which never pushes back.
`timescale 1ns/10ps
module rx_client_sink (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // client stream
  input wire logic cl_valid,
  input wire logic cl_eop,
  input wire logic [255:0] cl_data,
  input wire logic [4:0] cl_empty,
  input wire logic [1:0] cl_error,
  input wire logic cl_fcs_valid,
  input wire logic cl_fcs_error,
  input wire logic [2:0] cl_ctrl_kind,
  // log
  output logic [15:0] words_q,
  output logic [15:0] eops_q,
  output logic [255:0] data_q,
  output logic [9:0] flags_q,
  output logic [1:0] fcs_q
);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      words_q <= 16'h0;
      eops_q <= 16'h0;
      flags_q <= 10'h0;
      fcs_q <= 2'h0;
    end else begin
      if (cl_valid) begin
        words_q <= words_q + 16'h1;
      end
      // flags taken on end word only
      if (cl_valid && cl_eop) begin
        eops_q <= eops_q + 16'h1;
        data_q <= cl_data;
        flags_q <= {cl_empty, cl_error, cl_ctrl_kind};
      end
      if (cl_fcs_valid) begin
        fcs_q <= {cl_eop, cl_fcs_error};
      end
    end
  end
endmodule : rx_client_sink

/* bench/test_rx_mac_frame_checker.sv */
// self-checking bench for the receive frame checker: wishbone registers,
// link frames built with their own crc, client side logged by the sink.
// assumes default build: strict checks, end-aligned fcs, standard pause.
`timescale 1ns/10ps
module test_rx_mac_frame_checker;
  import rx_frame_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic ack, lv = 1'b0, lc = 1'b0, preq, ppfc, cv, eop, fv, fe, sop, gap;
  int sops = 0, gaps = 0;
  logic [7:0] lb = 8'h0;
  logic [255:0] cd, data_q;
  logic [4:0] emp;
  logic [1:0] err, fcs_q;
  logic [2:0] kind;
  logic [15:0] pq, words_q, eops_q;
  logic [9:0] flags_q;
  logic [7:0] pl [0:63];
  logic [15:0] ops [4] = '{OP_STD_PAUSE, OP_PFC_PAUSE, 16'h0002, OP_STD_PAUSE};
  logic [2:0] kinds [4] = '{KIND_STD, KIND_PFC, KIND_OTHER, KIND_STD};
  int checked = 0, miscompares = 0, exp_eops = 0, pulses = 0, cycles = 0, n, p0;
  int seed = 32'h9FE34634;

  always #25 clk_sys = ~clk_sys;

  rx_mac_frame_checker u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .lnk_valid(lv), .lnk_ctrl(lc),
    .lnk_byte(lb), .cl_valid(cv), .cl_sop(sop), .cl_eop(eop), .cl_gap(gap), .cl_data(cd),
    .cl_empty(emp), .cl_error(err), .cl_fcs_valid(fv), .cl_fcs_error(fe),
    .cl_ctrl_kind(kind), .pause_req(preq), .pause_pfc(ppfc), .pause_quanta(pq));

  rx_client_sink u_sink (.clk_sys(clk_sys), .rst_n(rst_n), .cl_valid(cv), .cl_eop(eop),
    .cl_data(cd), .cl_empty(emp), .cl_error(err), .cl_fcs_valid(fv), .cl_fcs_error(fe),
    .cl_ctrl_kind(kind), .words_q(words_q), .eops_q(eops_q), .data_q(data_q),
    .flags_q(flags_q), .fcs_q(fcs_q));

  always @(posedge clk_sys) begin
    pulses += (preq === 1'b1);
    sops += (cv === 1'b1 && sop === 1'b1);
    gaps += (gap !== 1'b0);
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic check_reg(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check_reg

  task automatic check_word(input string nm, input logic [255:0] e, input logic [255:0] s);
    checked++;
    if (e !== s) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check_word

  // held until ack is seen, released on that same edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    if (k >= 50) miscompares++;
  endtask : wb

  task automatic oct(input logic c, input logic [7:0] b);
    @(posedge clk_sys);
    lc <= c;
    lb <= b;
    lv <= 1'b1;
  endtask : oct

  function automatic logic [255:0] word_of(input int k);
    logic [255:0] w;
    w = '0;
    for (int i = 0; i < k; i++) w[255-8*i -: 8] = pl[i];
    return w;
  endfunction : word_of

  // fcs sent low byte first, so its first bit is the top crc term
  task automatic frame(input int k, input logic [7:0] st, pr, dl, input logic [31:0] fx,
      input logic [7:0] ec);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < k; i++)
      for (int b = 0; b < 8; b++) c = (c[0] ^ pl[i][b]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    c = ~c ^ fx;
    for (int i = 0; i < 4; i++) pl[k+i] = c[8*i +: 8];
    oct(1'b1, st);
    repeat (6) oct(1'b0, pr);
    oct(1'b0, dl);
    for (int i = 0; i < k + 4; i++) oct(1'b0, pl[i]);
    oct(1'b1, ec);
    oct(1'b1, TERM_CHAR);
    repeat (4) oct(1'b1, 8'h07);
  endtask : frame

  // k is the delivered byte count, zero for a dropped frame
  task automatic run(input int m, input logic [7:0] st, pr, dl, input logic [31:0] fx,
      input logic [7:0] ec, input int k, input logic [1:0] er, input logic [2:0] kd);
    int sh;
    sh = 8 * (32 - k);
    frame(m, st, pr, dl, fx, ec);
    if (k > 0) exp_eops++;
    check_reg("frames", exp_eops, eops_q);
    check_reg("words", eops_q, words_q);
    check_reg("sops", exp_eops, sops);
    check_reg("gaps", 0, gaps);
    if (k > 0) begin
      check_reg("flags", {er, kd}, flags_q[4:0]);
      check_reg("fcs", {1'b1, er[1]}, fcs_q);
    end
    if (k > 0 && er == 2'b00) begin
      check_reg("empty", 32 - k, flags_q[9:5]);
      check_word("data", word_of(k) >> sh, data_q >> sh);
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    check_reg("width", 256, $bits(cd));
    wb(1'b0, 16'h1428, 0);
    check_reg("control", 32'h0, rd);
    wb(1'b0, 16'h142C, 0);
    check_reg("strip", 32'h1, rd);
    wb(1'b0, 16'h1430, 0);
    check_reg("pause en", 32'h3, rd);
    wb(1'b0, 16'h0000, 0);
    check_reg("unmapped", 32'h0, rd);
    repeat (6) begin
      n = 18 + ($unsigned($random(seed)) % 11);
      for (int i = 0; i < 32; i++) pl[i] = $random(seed);
      pl[12] = 8'h00;
      run(n, START_CHAR, PREAMBLE_BYTE, FRAME_START_DELIMITER, 0, TERM_CHAR, n, 2'b00, KIND_NONE);
    end
    wb(1'b1, 16'h142C, 0);
    wb(1'b0, 16'h142C, 0);
    check_reg("strip off", 32'h0, rd);
    run(20, START_CHAR, PREAMBLE_BYTE, FRAME_START_DELIMITER, 0, TERM_CHAR, 24, 2'b00, KIND_NONE);
    wb(1'b1, 16'h142C, 1);
    run(20, START_CHAR, PREAMBLE_BYTE, FRAME_START_DELIMITER, 1, TERM_CHAR, 20, 2'b10, KIND_NONE);
    run(20, START_CHAR, PREAMBLE_BYTE, FRAME_START_DELIMITER, 0, 8'hFE, 20, 2'b11, KIND_NONE);
    run(20, START_CHAR, PREAMBLE_BYTE, FRAME_START_DELIMITER, 0, 8'h07, 20, 2'b11, KIND_NONE);
    run(20, 8'hFC, PREAMBLE_BYTE, FRAME_START_DELIMITER, 0, TERM_CHAR, 0, 2'b00, KIND_NONE);
    wb(1'b1, 16'h1428, 32'h10);
    run(20, START_CHAR, 8'h54, FRAME_START_DELIMITER, 0, TERM_CHAR, 0, 2'b00, KIND_NONE);
    wb(1'b1, 16'h1428, 32'h08);
    run(20, START_CHAR, PREAMBLE_BYTE, 8'hD4, 0, TERM_CHAR, 0, 2'b00, KIND_NONE);
    wb(1'b1, 16'h1428, 32'h18);
    run(20, START_CHAR, PREAMBLE_BYTE, FRAME_START_DELIMITER, 0, TERM_CHAR, 20, 2'b00, KIND_NONE);
    wb(1'b1, 16'h1428, 32'h00);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wb(1'b1, 16'h1430, 0);
      {pl[12], pl[13], pl[14], pl[15], pl[16], pl[17]} = {CTRL_ETHERTYPE, ops[i], 16'h1234};
      p0 = pulses;
      run(24, START_CHAR, PREAMBLE_BYTE, FRAME_START_DELIMITER, 0, TERM_CHAR, 24, 2'b00, kinds[i]);
      check_reg("pause", p0 + (i == 0), pulses);
    end
    check_reg("quanta", 32'h1234, pq);
    check_reg("pfc", 32'h0, ppfc);
    close_out();
  end
endmodule : test_rx_mac_frame_checker

/* core/rx_frame_pkg.sv */
// constants for the receive frame checker: register map, link codes,
// header layout and client bus widths.
// assumes a byte-wide decoded link with a control flag per octet.
//
// Overview of operation
// [RL1] only start byte 0xFB opens a frame
// [RL2] strict build compares delimiter and preamble bytes
// [RL3] control bits 4 and 3 enable checks
// [RL4] failed preamble or delimiter drops whole packet
// [RL5] crc strip bit 0, set after reset
// [RL6] end marker on last delivered byte
// [RL7] fcs error, fcs valid, error bit 1 together
// [RL8] fcs error with end, or one later
// [RL9] first fcs bit is the x32 term
// [RL10] terminate ends the packet normally
// [RL11] error character ends packet, malformed and fcs
// [RL12] other control character ends packet likewise
// [RL13] late terminate gives no second end
// [RL14] inserted link errors count as malformed
// [RL15] gap octets dropped, forwarded in custom build
// [RL16] pause acted on only when enabled
// [RL17] all control frames reach the client unchanged
// [RL18] one-hot control frame kind, zero otherwise
// [RL19] client bus 256 or 128 bits wide
// [RL20] start, six preamble bytes, then delimiter
// [RL21] empty counts unused low bytes at end
// [RL22] client samples flags only when qualified
package rx_frame_pkg;
  localparam logic [7:0] START_CHAR = 8'hFB;
  localparam logic [7:0] TERM_CHAR = 8'hFD;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] FRAME_START_DELIMITER = 8'hD5;
  localparam logic [2:0] PREAMBLE_LEN = 3'h6;
  localparam int STD_DW = 256;
  localparam int CUSTOM_DW = 128;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_RX_FRAME_CHECK_CONTROL = 14'h050A;
  localparam logic [13:0] IDX_RX_CRC_STRIP_CONFIG = 14'h050B;
  localparam logic [13:0] IDX_RX_PAUSE_ENABLE = 14'h050C;
  localparam logic [13:0] IDX_RX_FRAME_STATUS = 14'h050D;
  localparam int BIT_PREAMBLE_CHK = 4;
  localparam int BIT_DELIM_CHK = 3;
  localparam int BIT_CRC_STRIP = 0;
  localparam int BIT_PAUSE_STD = 0;
  localparam int BIT_PAUSE_PFC = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic CRC_STRIP_RESET = 1'b1;
  localparam logic [1:0] PAUSE_EN_RESET = 2'h3;
  // reflected crc-32, lsb first on the wire
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [2:0] FCS_LEN = 3'h4;
  localparam logic [4:0] HDR_END = 5'h12;
  localparam logic [15:0] CTRL_ETHERTYPE = 16'h8808;
  localparam logic [15:0] OP_STD_PAUSE = 16'h0001;
  localparam logic [15:0] OP_PFC_PAUSE = 16'h0101;
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_STD = 3'h1;
  localparam logic [2:0] KIND_PFC = 3'h2;
  localparam logic [2:0] KIND_OTHER = 3'h4;
  typedef enum logic [1:0] {FLOW_NONE, FLOW_STD, FLOW_PFC} flow_mode_t;
endpackage : rx_frame_pkg

/* core/rx_mac_frame_checker.sv */
// receive frame checker: preamble check, fcs strip and check,
// malformed end handling, control frame flagging, wishbone registers.
// assumes one link octet per enabled cycle, no client back-pressure.
`timescale 1ns/10ps
module rx_mac_frame_checker #(
  parameter bit STRICT = 1'b1,
  parameter bit ALIGN_EOP = 1'b1,
  parameter bit CUSTOM_IF = 1'b0,
  parameter rx_frame_pkg::flow_mode_t FLOW_MODE = rx_frame_pkg::FLOW_STD,
  // [RL19] client width from build choice
  localparam int DW = CUSTOM_IF ? rx_frame_pkg::CUSTOM_DW : rx_frame_pkg::STD_DW
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link octets
  input wire logic lnk_valid,
  input wire logic lnk_ctrl,
  input wire logic [7:0] lnk_byte,
  // client stream
  output logic cl_valid,
  output logic cl_sop,
  output logic cl_eop,
  output logic cl_gap,
  output logic [DW-1:0] cl_data,
  output logic [4:0] cl_empty,
  output logic [1:0] cl_error,
  output logic cl_fcs_valid,
  output logic cl_fcs_error,
  output logic [2:0] cl_ctrl_kind,
  // pause towards transmit side
  output logic pause_req,
  output logic pause_pfc,
  output logic [15:0] pause_quanta
);
  import rx_frame_pkg::*;

  localparam int BYTES = DW / 8;
  localparam logic [5:0] BYTES_W = 6'(BYTES);

  typedef enum logic [1:0] {S_IDLE, S_PRE, S_DATA, S_DROP} state_t;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  ////////////////////////////////////////////////////////////////////
  // registers

  logic ack_q;
  logic wb_hit;
  logic [13:0] idx;
  logic [7:0] rx_frame_check_control_q;
  logic rx_crc_strip_config_q;
  logic [1:0] rx_pause_enable_q;
  logic last_fcs_bad_q;
  logic last_mal_q;
  state_t st_q;

  assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;
  assign idx = wb_adr_i[15:2];
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      ack_q <= wb_hit;
      wb_dat_o <= 32'h00000000;
      if (wb_hit && !wb_we_i) begin
        unique case (idx)
          IDX_RX_FRAME_CHECK_CONTROL: wb_dat_o <= {24'h000000, rx_frame_check_control_q};
          IDX_RX_CRC_STRIP_CONFIG: wb_dat_o <= {31'h00000000, rx_crc_strip_config_q};
          IDX_RX_PAUSE_ENABLE: wb_dat_o <= {30'h00000000, rx_pause_enable_q};
          IDX_RX_FRAME_STATUS:
            wb_dat_o <= {29'h00000000, last_fcs_bad_q, last_mal_q, st_q != S_IDLE};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_frame_check_control_q <= CONTROL_RESET;
      // [RL5] strip on after reset
      rx_crc_strip_config_q <= CRC_STRIP_RESET;
      rx_pause_enable_q <= PAUSE_EN_RESET;
    end else if (ce && wb_hit && wb_we_i && wb_sel_i[0]) begin
      unique case (idx)
        IDX_RX_FRAME_CHECK_CONTROL: rx_frame_check_control_q <= wb_dat_i[7:0];
        IDX_RX_CRC_STRIP_CONFIG: rx_crc_strip_config_q <= wb_dat_i[BIT_CRC_STRIP];
        IDX_RX_PAUSE_ENABLE: rx_pause_enable_q <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link parser

  logic [2:0] pcnt_q;
  logic pre_bad_q;
  logic [31:0] crc_q;
  logic [4:0] bcnt_q;
  logic [47:0] hdr_q;
  logic [7:0] dly_q [4];
  logic [2:0] dcnt_q;
  logic strip_f_q;
  logic first_q;
  logic [5:0] wcnt_q;
  logic [DW-1:0] wbuf_q;
  logic in_v;
  logic pre_chk;
  logic delim_chk;
  logic pre_fail;
  logic end_ev;
  logic mal;
  logic fcs_bad;
  logic push_v;
  logic [7:0] push_b;
  logic [5:0] last_cnt;
  logic [2:0] kind;

  assign in_v = ce && lnk_valid;
  // [RL3] strict checks only when built in
  assign pre_chk = STRICT && rx_frame_check_control_q[BIT_PREAMBLE_CHK];
  assign delim_chk = STRICT && rx_frame_check_control_q[BIT_DELIM_CHK];
  // [RL2] compare delimiter at the eighth octet
  assign pre_fail = pre_bad_q || (delim_chk && lnk_byte != FRAME_START_DELIMITER);
  // [RL10] any control octet closes a frame
  assign end_ev = in_v && st_q == S_DATA && lnk_ctrl;
  // [RL14] inserted errors arrive as error octets
  assign mal = lnk_byte != TERM_CHAR;
  // [RL9] reflected crc puts the first fcs bit at x32
  assign fcs_bad = mal || crc_q != CRC_RESIDUE;
  // [RL5] strip holds back the last four octets
  assign push_v = in_v && st_q == S_DATA && !lnk_ctrl && (!strip_f_q || dcnt_q == FCS_LEN);
  assign push_b = strip_f_q ? dly_q[3] : lnk_byte;
  assign last_cnt = (wcnt_q == 6'h00) ? 6'h01 : wcnt_q;

  // [RL18] one-hot kind from type and opcode
  always_comb begin
    kind = KIND_NONE;
    if (bcnt_q == HDR_END && hdr_q[47:32] == CTRL_ETHERTYPE) begin
      if (hdr_q[31:16] == OP_STD_PAUSE) begin
        kind = KIND_STD;
      end else if (hdr_q[31:16] == OP_PFC_PAUSE) begin
        kind = KIND_PFC;
      end else begin
        kind = KIND_OTHER;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      pcnt_q <= 3'h0;
      pre_bad_q <= 1'b0;
      strip_f_q <= 1'b1;
    end else if (in_v) begin
      unique case (st_q)
        S_IDLE: begin
          // [RL1] only a start octet opens a frame
          if (lnk_ctrl && lnk_byte == START_CHAR) begin
            st_q <= S_PRE;
            pcnt_q <= 3'h0;
            pre_bad_q <= 1'b0;
          end
        end
        S_PRE: begin
          // [RL20] start, six preamble octets, delimiter
          if (lnk_ctrl) begin
            st_q <= S_IDLE;
          end else if (pcnt_q != PREAMBLE_LEN) begin
            pcnt_q <= pcnt_q + 3'h1;
            if (pre_chk && lnk_byte != PREAMBLE_BYTE) begin
              pre_bad_q <= 1'b1;
            end
          end else begin
            // [RL4] bad preamble drops the packet
            st_q <= pre_fail ? S_DROP : S_DATA;
            strip_f_q <= rx_crc_strip_config_q;
          end
        end
        S_DATA: begin
          // [RL13] back to idle, a later terminate is ignored
          if (lnk_ctrl) begin
            st_q <= S_IDLE;
          end
        end
        S_DROP: begin
          if (lnk_ctrl) begin
            st_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // crc, header capture and fcs delay line
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      crc_q <= CRC_INIT;
      bcnt_q <= 5'h00;
      hdr_q <= 48'h000000000000;
      dcnt_q <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        dly_q[i] <= 8'h00;
      end
    end else if (in_v) begin
      if (st_q != S_DATA) begin
        crc_q <= CRC_INIT;
        bcnt_q <= 5'h00;
        dcnt_q <= 3'h0;
      end else if (!lnk_ctrl) begin
        crc_q <= crc_byte(crc_q, lnk_byte);
        if (bcnt_q != HDR_END) begin
          bcnt_q <= bcnt_q + 5'h01;
          hdr_q <= {hdr_q[39:0], lnk_byte};
        end
        dly_q[0] <= lnk_byte;
        for (int i = 1; i < 4; i++) begin
          dly_q[i] <= dly_q[i-1];
        end
        if (dcnt_q != FCS_LEN) begin
          dcnt_q <= dcnt_q + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // client word assembly; one word is held back so the end marker
  // can land on it even when the frame fills it exactly

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wbuf_q <= '0;
      wcnt_q <= 6'h00;
      first_q <= 1'b1;
      cl_valid <= 1'b0;
      cl_sop <= 1'b0;
      cl_eop <= 1'b0;
      cl_gap <= 1'b0;
      cl_data <= '0;
      cl_empty <= 5'h00;
      cl_ctrl_kind <= KIND_NONE;
      last_mal_q <= 1'b0;
    end else if (ce) begin
      cl_valid <= 1'b0;
      cl_sop <= 1'b0;
      cl_eop <= 1'b0;
      cl_gap <= 1'b0;
      cl_empty <= 5'h00;
      cl_ctrl_kind <= KIND_NONE;
      // [RL15] custom build forwards gap octets one per word
      if (CUSTOM_IF && in_v && st_q == S_IDLE) begin
        cl_valid <= 1'b1;
        cl_gap <= 1'b1;
        cl_data <= {lnk_byte, {(DW-8){1'b0}}};
        cl_empty <= 5'(BYTES - 1);
      end
      if (push_v) begin
        if (wcnt_q == BYTES_W) begin
          cl_valid <= 1'b1;
          cl_sop <= first_q;
          cl_data <= wbuf_q;
          first_q <= 1'b0;
          wbuf_q <= {push_b, {(DW-8){1'b0}}};
          wcnt_q <= 6'h01;
        end else begin
          wbuf_q[DW-1-8*wcnt_q -: 8] <= push_b;
          wcnt_q <= wcnt_q + 6'h01;
        end
      end
      // [RL6] end lands on the last octet kept
      if (end_ev) begin
        cl_valid <= 1'b1;
        cl_sop <= first_q;
        cl_eop <= 1'b1;
        cl_data <= wbuf_q;
        // [RL21] unused octets at the low end
        cl_empty <= 5'(BYTES_W - last_cnt);
        // [RL17] control frames pass, only flagged
        cl_ctrl_kind <= kind;
        // [RL11] [RL12] malformed end
        last_mal_q <= mal;
        wcnt_q <= 6'h00;
        first_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fcs result timing and pause action

  logic fp_q;
  logic fb_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fp_q <= 1'b0;
      fb_q <= 1'b0;
      cl_fcs_valid <= 1'b0;
      cl_fcs_error <= 1'b0;
      last_fcs_bad_q <= 1'b0;
    end else if (ce) begin
      fp_q <= end_ev;
      fb_q <= end_ev && fcs_bad;
      // [RL8] aligned with end, or the cycle after
      cl_fcs_valid <= ALIGN_EOP ? end_ev : fp_q;
      // [RL7] error only ever rides with valid
      cl_fcs_error <= ALIGN_EOP ? (end_ev && fcs_bad) : fb_q;
      if (end_ev) begin
        last_fcs_bad_q <= fcs_bad;
      end
    end
  end

  // [RL7] error bit 1 mirrors the fcs error
  assign cl_error = {cl_fcs_error, cl_eop && last_mal_q};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pause_req <= 1'b0;
      pause_pfc <= 1'b0;
      pause_quanta <= 16'h0000;
    end else if (ce) begin
      pause_req <= 1'b0;
      // [RL16] act only on good frames, mode built and enabled
      if (end_ev && !fcs_bad) begin
        if ((kind == KIND_STD && FLOW_MODE == FLOW_STD && rx_pause_enable_q[BIT_PAUSE_STD])
            || (kind == KIND_PFC && FLOW_MODE == FLOW_PFC
                && rx_pause_enable_q[BIT_PAUSE_PFC])) begin
          pause_req <= 1'b1;
          pause_pfc <= kind == KIND_PFC;
          pause_quanta <= hdr_q[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_fcs_pair: assert property (cl_fcs_error |-> cl_fcs_valid && cl_error[1]) // [RL7]
    else $error("fcs error without fcs valid or error bit");
  a_fcs_align: assert property (ALIGN_EOP && cl_fcs_valid |-> cl_eop && cl_valid) // [RL8]
    else $error("aligned fcs result not on end cycle");
  a_fcs_late: assert property (ce && !ALIGN_EOP && end_ev |=> cl_eop ##1 cl_fcs_valid) // [RL8]
    else $error("late fcs result not one cycle after end");
  a_malformed_end: assert property (ce && end_ev && mal |=> cl_error[0] ##[0:1] cl_fcs_error) // [RL11]
    else $error("malformed end without error flags");
  a_kind_onehot: assert property ($onehot0(cl_ctrl_kind) && (!cl_eop -> cl_ctrl_kind == 3'h0)) // [RL18]
    else $error("control kind not one-hot");
  a_empty_mid: assert property (cl_valid && !cl_eop && !cl_gap |-> cl_empty == 5'h00) // [RL21]
    else $error("empty nonzero before end");
  a_strip_reset: assert property ($rose(rst_n) |-> rx_crc_strip_config_q) // [RL5]
    else $error("strip not enabled after reset");
  a_start_only: assert property (ce && st_q == S_IDLE && lnk_valid
      && !(lnk_ctrl && lnk_byte == START_CHAR) |=> st_q != S_PRE) // [RL1]
    else $error("frame opened without start octet");
  a_drop_silent: assert property (ce && st_q == S_DROP |=> !cl_eop) // [RL4]
    else $error("dropped packet reached client");
  a_no_second_end: assert property (ce && end_ev |=> st_q == S_IDLE) // [RL13]
    else $error("frame not closed after end");
  a_wb_ack: assert property (ce && wb_hit |=> wb_ack_o ##1 !wb_ack_o) // wishbone ack for one cycle, then low
    else $error("wishbone request not acknowledged");

  c_fcs_bad: cover property (cl_fcs_error);
  c_drop: cover property (st_q == S_DROP);
  c_pause: cover property (pause_req);
  c_malformed: cover property (cl_error[0]);
endmodule : rx_mac_frame_checker
